// ### pkg/sar_adc_pkg.sv
// constants and types shared by the converter sequencer files
package sar_adc_pkg;
	// register offsets (word indices on the plain register port)
	localparam logic [3:0] OFF_CTRL_ONE = 4'h0;
	localparam logic [3:0] OFF_CTRL_TWO = 4'h1;
	localparam logic [3:0] OFF_CTRL_THREE = 4'h2;
	localparam logic [3:0] OFF_CHAN_SEL = 4'h3;
	localparam logic [3:0] OFF_SCAN_LOW = 4'h4;
	localparam logic [3:0] OFF_SCAN_HIGH = 4'h5;
	localparam logic [3:0] OFF_BUF_INDEX = 4'h6;
	localparam logic [3:0] OFF_BUF_DATA = 4'h7;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	// control one fields
	localparam int CTRL1_ENABLE = 15;
	localparam int CTRL1_IDLE_STOP = 13;
	localparam int CTRL1_FORMAT = 8;
	localparam int CTRL1_TRIGGER = 5;
	localparam int CTRL1_AUTO_START = 2;
	localparam int CTRL1_SAMPLE = 1;
	localparam int CTRL1_DONE = 0;
	localparam logic [15:0] CTRL1_WMASK = 16'hA3E6;
	// control two fields
	localparam int CTRL2_REF = 13;
	localparam int CTRL2_SCAN = 10;
	localparam int CTRL2_HALF = 7;
	localparam int CTRL2_SEQ = 2;
	localparam int CTRL2_SPLIT = 1;
	localparam int CTRL2_ALT = 0;
	localparam logic [15:0] CTRL2_WMASK = 16'hE47F;
	// control three fields
	localparam int CTRL3_RC = 15;
	localparam int CTRL3_SAMPLE_TIME = 8;
	localparam logic [15:0] CTRL3_WMASK = 16'h9FFF;
	localparam logic [15:0] CHAN_WMASK = 16'h9F9F;
	localparam logic [15:0] SCAN_HIGH_WMASK = 16'h0FFF;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	// trigger source codes
	localparam logic [2:0] TRIG_MANUAL = 3'h0;
	localparam logic [2:0] TRIG_PIN = 3'h1;
	localparam logic [2:0] TRIG_TIMER_A = 3'h2;
	localparam logic [2:0] TRIG_TIMER_B = 3'h4;
	localparam logic [2:0] TRIG_CHARGE = 3'h6;
	localparam logic [2:0] TRIG_COUNTER = 3'h7;
	localparam int RESULT_BITS = 10;
	localparam int BUF_WORDS = 32;
	localparam int SCAN_CHANNELS = 28;
	typedef enum logic [1:0] {
		FMT_UINT, FMT_SINT, FMT_FRAC, FMT_SFRAC
	} format_t;
endpackage

// ### pkg/conv_if.sv
// carrier between sequencer and result store
`timescale 1ns/100ps
interface conv_if;
	logic write_en;
	logic [4:0] write_index;
	logic [9:0] write_data;
	logic clear;
	logic [4:0] read_index;
	logic [9:0] read_data;
	modport seq (output write_en, write_index, write_data, clear,
		read_index, input read_data);
	modport store (input write_en, write_index, write_data, clear,
		read_index, output read_data);
endinterface

// ### rtl/result_store.sv
// 32-word raw result storage in flip-flops
`timescale 1ns/100ps
module result_store (
	input wire logic clock_i,
	input wire logic rst_n_i,
	conv_if.store bus
);
	import sar_adc_pkg::*;
	typedef struct packed {
		logic [BUF_WORDS-1:0][RESULT_BITS-1:0] word;
	} store_state_t;
	store_state_t state, next_state;
	always_comb begin
		next_state = state;
		// contents are lost when the converter is turned off
		if (bus.clear) begin
			next_state.word = '0;
		end else if (bus.write_en) begin
			next_state.word[bus.write_index] = bus.write_data;
		end
	end
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign bus.read_data = state.word[bus.read_index];
endmodule

// ### rtl/sar_core.sv
// ten-step successive approximation engine
`timescale 1ns/100ps
module sar_core (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic step_i,
	input wire logic compare_i,
	output logic [9:0] trial_o,
	output logic busy_o,
	output logic done_o
);
	import sar_adc_pkg::*;
	typedef struct packed {
		logic [9:0] value;
		logic [9:0] bit_mask;
		logic busy;
		logic done;
	} core_state_t;
	core_state_t state, next_state;
	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		if (start_i) begin
			next_state.busy = 1'b1;
			next_state.bit_mask = 10'h200;
			next_state.value = 10'h200;
		end else if (state.busy && step_i) begin
			// keep the trial bit only if the input is above the trial level
			if (!compare_i) begin
				next_state.value = state.value & ~state.bit_mask;
			end
			next_state.bit_mask = state.bit_mask >> 1;
			next_state.value = next_state.value | (state.bit_mask >> 1);
			if (state.bit_mask == 10'h001) begin
				next_state.busy = 1'b0;
				next_state.done = 1'b1;
			end
		end
	end
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign trial_o = state.value;
	assign busy_o = state.busy;
	assign done_o = state.done;
endmodule

// ### rtl/sar_adc_sequencer.sv
// control and sequencing around a 10-bit successive-approximation converter
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
module sar_adc_sequencer (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [15:0] reg_rdata_o,
	input wire logic idle_mode_i,
	input wire logic rc_tick_i,
	input wire logic compare_i,
	input wire logic external_interrupt_pin_i,
	input wire logic charge_time_unit_i,
	input wire logic third_timer_i,
	input wire logic fifth_timer_i,
	output logic converter_irq_flag_o,
	output logic sampling_o,
	output logic [9:0] trial_o,
	output logic [4:0] positive_input_o,
	output logic negative_pin_o,
	output logic ref_positive_ext_o,
	output logic ref_negative_ext_o
);
	import sar_adc_pkg::*;

	typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_SAMPLE, ST_CONVERT} phase_t;

	typedef struct packed {
		logic [15:0] ctrl_one;
		logic [15:0] ctrl_two;
		logic [15:0] ctrl_three;
		logic [15:0] chan_sel;
		logic [15:0] scan_low;
		logic [15:0] scan_high;
		logic [4:0] read_index;
		logic [15:0] rdata;
		phase_t phase;
		logic [7:0] div_count;
		logic [4:0] sample_count;
		logic [4:0] seq_count;
		logic [4:0] write_ptr;
		logic [4:0] scan_pos;
		logic use_mux_b;
		logic buffer_half;
		logic irq;
		logic [2:0] pin_sync;
		logic [2:0] charge_sync;
		logic [2:0] timer_a_sync;
		logic [2:0] timer_b_sync;
		logic [1:0] idle_sync;
		logic [2:0] rc_sync;
		logic sampling;
		logic [4:0] pos_sel;
		logic neg_sel;
		logic ref_pos;
		logic ref_neg;
	} top_state_t;

	top_state_t state, next_state;
	conv_if cbus();
	logic core_start, core_busy, core_done, conv_tick;
	logic [9:0] core_value;

	// ==========================================================
	// formatting and channel helpers
	function automatic logic [15:0] format_result(logic [1:0] fmt,
		logic [9:0] raw);
		logic [9:0] offset;
		offset = raw ^ 10'h200;
		unique case (format_t'(fmt))
			FMT_UINT: format_result = {6'h00, raw};
			FMT_SINT: format_result = {{6{offset[9]}}, offset};
			FMT_FRAC: format_result = {raw, 6'h00};
			FMT_SFRAC: format_result = {offset, 6'h00};
		endcase
	endfunction

	// next selected scan channel after pos, wrapping
	function automatic logic [4:0] next_scan(logic [27:0] sel,
		logic [4:0] pos);
		logic [4:0] cand;
		next_scan = pos;
		for (int i = SCAN_CHANNELS; i >= 1; i--) begin
			cand = 5'((int'(pos) + i) % SCAN_CHANNELS);
			if (sel[cand]) begin
				next_scan = cand;
			end
		end
	endfunction

	// ==========================================================
	// conversion engine and storage
	sar_core u_core (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.start_i(core_start),
		.step_i(conv_tick),
		.compare_i(compare_i),
		.trial_o(core_value),
		.busy_o(core_busy),
		.done_o(core_done)
	);

	result_store u_store (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.bus(cbus.store)
	);

	// ==========================================================
	// sequencing
	logic enabled, run, trig_event, seq_end;
	logic [1:0] split_sel;
	logic [27:0] scan_mask;
	logic mux_b_now;
	logic [4:0] scan_now;

	always_comb begin
		next_state = state;
		// pins pass two flops before use
		next_state.pin_sync = {state.pin_sync[1:0], external_interrupt_pin_i};
		next_state.charge_sync = {state.charge_sync[1:0], charge_time_unit_i};
		next_state.timer_a_sync = {state.timer_a_sync[1:0], third_timer_i};
		next_state.timer_b_sync = {state.timer_b_sync[1:0], fifth_timer_i};
		next_state.idle_sync = {state.idle_sync[0], idle_mode_i};
		next_state.rc_sync = {state.rc_sync[1:0], rc_tick_i};
		scan_mask = {state.scan_high[11:0], state.scan_low};
		// mux b only counts while alternation is on
		mux_b_now = state.use_mux_b && state.ctrl_two[CTRL2_ALT];
		// a scan mask rewritten since the last step never leaves a stale pick
		scan_now = scan_mask[state.scan_pos] ? state.scan_pos
			: next_scan(scan_mask, state.scan_pos);
		enabled = state.ctrl_one[CTRL1_ENABLE];
		run = enabled && !(state.ctrl_one[CTRL1_IDLE_STOP]
			&& state.idle_sync[1]);
		split_sel = 2'b00;
		core_start = 1'b0;
		seq_end = 1'b0;
		conv_tick = 1'b0;
		cbus.write_en = 1'b0;
		cbus.write_index = state.write_ptr;
		cbus.write_data = core_value;
		cbus.clear = !enabled;
		cbus.read_index = state.read_index;

		// conversion period tick
		if (state.ctrl_three[CTRL3_RC]) begin
			conv_tick = state.rc_sync[1] && !state.rc_sync[2];
			next_state.div_count = 8'h00;
		end else if (state.div_count == state.ctrl_three[7:0]) begin
			conv_tick = 1'b1;
			next_state.div_count = 8'h00;
		end else begin
			next_state.div_count = state.div_count + 8'h01;
		end
		conv_tick = conv_tick && run;

		// conversion trigger selection
		unique case (state.ctrl_one[CTRL1_TRIGGER +: 3])
			TRIG_PIN: trig_event = state.pin_sync[1] && !state.pin_sync[2];
			TRIG_TIMER_A:
				trig_event = state.timer_a_sync[1] && !state.timer_a_sync[2];
			TRIG_TIMER_B:
				trig_event = state.timer_b_sync[1] && !state.timer_b_sync[2];
			TRIG_CHARGE:
				trig_event = state.charge_sync[1] && !state.charge_sync[2];
			TRIG_COUNTER: trig_event = conv_tick
				&& state.sample_count >= state.ctrl_three[12:8];
			TRIG_MANUAL: trig_event = !state.ctrl_one[CTRL1_SAMPLE];
			default: trig_event = 1'b0;
		endcase

		// register writes
		if (reg_write_i) begin
			unique case (reg_addr_i)
				OFF_CTRL_ONE: next_state.ctrl_one =
					(reg_wdata_i & CTRL1_WMASK)
					| (state.ctrl_one & ~CTRL1_WMASK);
				OFF_CTRL_TWO: next_state.ctrl_two =
					(reg_wdata_i & CTRL2_WMASK)
					| (state.ctrl_two & ~CTRL2_WMASK);
				OFF_CTRL_THREE: next_state.ctrl_three =
					reg_wdata_i & CTRL3_WMASK;
				OFF_CHAN_SEL: next_state.chan_sel = reg_wdata_i & CHAN_WMASK;
				OFF_SCAN_LOW: next_state.scan_low = reg_wdata_i;
				OFF_SCAN_HIGH: next_state.scan_high =
					reg_wdata_i & SCAN_HIGH_WMASK;
				OFF_BUF_INDEX: next_state.read_index = reg_wdata_i[4:0];
				default: ;
			endcase
		end

		// sample/convert phases
		unique case (state.phase)
			ST_OFF: begin
				next_state.ctrl_one[CTRL1_DONE] = 1'b0;
				// a sample request written with the enable is kept
				if (!next_state.ctrl_one[CTRL1_ENABLE]) begin
					next_state.ctrl_one[CTRL1_SAMPLE] = 1'b0;
				end
				if (next_state.ctrl_one[CTRL1_ENABLE]) begin
					next_state.phase = ST_IDLE;
					next_state.write_ptr = 5'h00;
					next_state.seq_count = 5'h00;
					next_state.use_mux_b = 1'b0;
					next_state.buffer_half = 1'b0;
					next_state.scan_pos = next_scan(scan_mask, 5'h1B);
				end
			end
			ST_IDLE: begin
				if (run && next_state.ctrl_one[CTRL1_SAMPLE]) begin
					next_state.phase = ST_SAMPLE;
					next_state.sample_count = 5'h00;
					next_state.ctrl_one[CTRL1_DONE] = 1'b0;
				end
			end
			ST_SAMPLE: begin
				if (conv_tick && state.sample_count != 5'h1F) begin
					next_state.sample_count = state.sample_count + 5'h01;
				end
				if (run && trig_event) begin
					next_state.phase = ST_CONVERT;
					next_state.ctrl_one[CTRL1_SAMPLE] = 1'b0;
					core_start = 1'b1;
				end
			end
			ST_CONVERT: begin
				if (core_done) begin
					cbus.write_en = 1'b1;
					seq_end = 1'b1;
					next_state.ctrl_one[CTRL1_DONE] = 1'b1;
					if (state.ctrl_one[CTRL1_AUTO_START]) begin
						next_state.ctrl_one[CTRL1_SAMPLE] = 1'b1;
						next_state.phase = ST_SAMPLE;
						next_state.sample_count = 5'h00;
					end else begin
						next_state.phase = ST_IDLE;
					end
				end
			end
		endcase

		// end of a sequence: pointer, mux, scan and interrupt pacing
		next_state.irq = 1'b0;
		if (seq_end) begin
			next_state.write_ptr = state.write_ptr + 5'h01;
			if (state.ctrl_two[CTRL2_ALT]) begin
				next_state.use_mux_b = !state.use_mux_b;
			end else begin
				next_state.use_mux_b = 1'b0;
			end
			if (state.ctrl_two[CTRL2_SCAN] && !mux_b_now) begin
				next_state.scan_pos = next_scan(scan_mask,
					scan_now);
			end
			if (state.seq_count == state.ctrl_two[CTRL2_SEQ +: 5]) begin
				next_state.seq_count = 5'h00;
				next_state.irq = 1'b1;
				// each interrupt period scans from the first channel again
				next_state.scan_pos = next_scan(scan_mask, 5'h1B);
				if (state.ctrl_two[CTRL2_SPLIT]) begin
					next_state.buffer_half = !state.buffer_half;
					next_state.write_ptr = {!state.buffer_half, 4'h0};
				end else begin
					next_state.buffer_half = 1'b0;
					next_state.write_ptr = 5'h00;
				end
			end else begin
				next_state.seq_count = state.seq_count + 5'h01;
				if (state.ctrl_two[CTRL2_SPLIT]) begin
					// stay within the half being filled
					next_state.write_ptr = {state.buffer_half,
						4'(state.write_ptr[3:0] + 4'h1)};
				end
			end
		end
		next_state.ctrl_two[CTRL2_HALF] =
			next_state.buffer_half && state.ctrl_two[CTRL2_SPLIT];

		// input selection for the next sample
		split_sel = {mux_b_now, state.ctrl_two[CTRL2_SCAN]};
		unique case (split_sel)
			2'b00: next_state.pos_sel = state.chan_sel[4:0];
			2'b01: next_state.pos_sel = scan_now;
			default: next_state.pos_sel = state.chan_sel[12:8];
		endcase
		next_state.neg_sel = mux_b_now ? state.chan_sel[15]
			: state.chan_sel[7];
		next_state.sampling = (next_state.phase == ST_SAMPLE)
			&& next_state.ctrl_one[CTRL1_ENABLE];
		next_state.ref_pos = next_state.ctrl_two[15:13] == 3'h1
			|| next_state.ctrl_two[15:13] == 3'h3;
		next_state.ref_neg = next_state.ctrl_two[15:13] == 3'h2
			|| next_state.ctrl_two[15:13] == 3'h3;

		// turning off forces the phase to ST_OFF; pointer, mux and scan restart on the next enable
		if (!next_state.ctrl_one[CTRL1_ENABLE]) begin
			next_state.phase = ST_OFF;
		end

		// read data, valid one cycle after the strobe
		next_state.rdata = 16'h0000;
		if (reg_read_i) begin
			unique case (reg_addr_i)
				OFF_CTRL_ONE: next_state.rdata = state.ctrl_one;
				OFF_CTRL_TWO: next_state.rdata = state.ctrl_two;
				OFF_CTRL_THREE: next_state.rdata = state.ctrl_three;
				OFF_CHAN_SEL: next_state.rdata = state.chan_sel;
				OFF_SCAN_LOW: next_state.rdata = state.scan_low;
				OFF_SCAN_HIGH: next_state.rdata = state.scan_high;
				OFF_BUF_INDEX: next_state.rdata = {11'h000, state.read_index};
				OFF_BUF_DATA: next_state.rdata = format_result(
					state.ctrl_one[CTRL1_FORMAT +: 2], cbus.read_data);
				OFF_STATUS: next_state.rdata = {9'h000, core_busy,
					state.write_ptr, state.use_mux_b};
				default: next_state.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata_o = state.rdata;
	assign converter_irq_flag_o = state.irq;
	assign sampling_o = state.sampling;
	assign trial_o = core_value;
	assign positive_input_o = state.pos_sel;
	assign negative_pin_o = state.neg_sel;
	assign ref_positive_ext_o = state.ref_pos;
	assign ref_negative_ext_o = state.ref_neg;

	// ==========================================================
	// checks
	chk_off_no_sample: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) !state.ctrl_one[CTRL1_ENABLE]
		|=> !state.sampling) else $error("sampling while off");
	chk_done_on_end: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) seq_end && state.ctrl_one[CTRL1_ENABLE]
		|=> state.ctrl_one[CTRL1_DONE]) else $error("done missing");
	chk_auto_restart: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) seq_end && state.ctrl_one[CTRL1_AUTO_START]
		&& next_state.ctrl_one[CTRL1_ENABLE] |=> state.phase == ST_SAMPLE)
		else $error("no auto restart");
	chk_irq_pacing: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) next_state.irq |-> seq_end
		&& state.seq_count == state.ctrl_two[CTRL2_SEQ +: 5])
		else $error("irq pacing wrong");
	chk_ptr_rewind: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) next_state.irq
		&& !state.ctrl_two[CTRL2_SPLIT] && enabled |=> state.write_ptr == 5'h00)
		else $error("pointer not rewound");
	chk_sample_hold: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) core_start |=> !state.ctrl_one[CTRL1_SAMPLE])
		else $error("sample bit stuck");
	chk_ref_default: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) state.ctrl_two[15] |-> !ref_positive_ext_o
		&& !ref_negative_ext_o) else $error("bad reference");
	chk_idle_stop: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) state.ctrl_one[CTRL1_IDLE_STOP]
		&& state.idle_sync[1] |-> !core_start && !conv_tick)
		else $error("ran during idle");
endmodule

// ### tb/sar_adc_sequencer_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module sar_adc_sequencer_tb;
	import sar_adc_pkg::*;
	logic clock_i, rst_n_i, reg_write_i, reg_read_i, idle_mode_i, rc_tick_i;
	logic [3:0] reg_addr_i, trig;
	logic [15:0] reg_wdata_i, reg_rdata_o, v, h;
	logic converter_irq_flag_o, sampling_o, negative_pin_o;
	logic ref_positive_ext_o, ref_negative_ext_o;
	logic [9:0] trial_o, level;
	logic [4:0] positive_input_o;
	logic [5:0] mx;
	int fails, total_checks, cycles, irqs, b, i, w, g;
	// ==========================================================
	// analog input model: sits half a step above level
	wire compare_i_w;
	assign compare_i_w = (trial_o <= level);
	sar_adc_sequencer dut_u (
		.clock_i(clock_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o), .idle_mode_i(idle_mode_i),
		.rc_tick_i(rc_tick_i), .compare_i(compare_i_w),
		.external_interrupt_pin_i(trig[0]),
		.third_timer_i(trig[1]), .fifth_timer_i(trig[2]),
		.charge_time_unit_i(trig[3]),
		.converter_irq_flag_o(converter_irq_flag_o),
		.sampling_o(sampling_o), .trial_o(trial_o),
		.positive_input_o(positive_input_o),
		.negative_pin_o(negative_pin_o),
		.ref_positive_ext_o(ref_positive_ext_o),
		.ref_negative_ext_o(ref_negative_ext_o));
	// ==========================================================
	// clock, hang guard, interrupt pulse count
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (converter_irq_flag_o === 1'b1) irqs <= irqs + 1;
		if (cycles == 40000) begin
			fails++;
			results();
		end
	end
	// ==========================================================
	task automatic results;
		if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e,
		input string nm);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clock_i);
		reg_write_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge clock_i);
		reg_read_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] m,
		input logic [15:0] e, input string nm);
		logic [15:0] d;
		rd(a, d);
		chk(d & m, e, nm);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	// waits for a level on sampling_o, counting cycles
	task automatic until_smp(input logic l, output int n);
		n = 0;
		#1;
		while (sampling_o !== l && n < 500) begin
			step(1);
			n++;
		end
	endtask
	// one manual sample and convert, mux choice kept in mx
	task automatic conv(input logic [15:0] c);
		wr(OFF_CTRL_ONE, c | 16'h0002);
		step(2);
		chk(16'(sampling_o), 16'h0001, "sampling");
		mx = {negative_pin_o, positive_input_o};
		wr(OFF_CTRL_ONE, c);
		step(12);
		v = '0;
		for (int k = 0; k < 60 && v[0] !== 1'b1; k++) rd(OFF_CTRL_ONE, v);
		chk(v & 16'h0003, 16'h0001, "done");
		chk(16'(trial_o), 16'(level), "trial");
	endtask
	function automatic logic [15:0] fmt(int f, logic [9:0] d);
		logic [9:0] s;
		s = d ^ 10'h200;
		case (f)
		0: return {6'h00, d};
		1: return {{6{s[9]}}, s};
		2: return {d, 6'h00};
		default: return {s, 6'h00};
		endcase
	endfunction
	// ==========================================================
	initial begin
		{rst_n_i, reg_write_i, reg_read_i, idle_mode_i, rc_tick_i} = '0;
		reg_addr_i = '0;
		reg_wdata_i = '0;
		trig = '0;
		level = 10'h000;
		{fails, total_checks, cycles, irqs} = '0;
		repeat (12) @(posedge clock_i);
		rst_n_i <= 1'b1;
		rchk(OFF_CTRL_ONE, 16'hFFFF, RESET_VALUE, "ctrl1");
		wr(OFF_CTRL_THREE, 16'hFFFF);
		rchk(OFF_CTRL_THREE, 16'hFFFF, CTRL3_WMASK, "ctrl3");
		wr(OFF_CTRL_TWO, 16'hFFFF);
		rchk(OFF_CTRL_TWO, 16'hFFFF, CTRL2_WMASK, "ctrl2");
		wr(4'hF, 16'hFFFF);
		rchk(4'hF, 16'hFFFF, 16'h0000, "unmapped");
		for (i = 0; i < 8; i++) begin
			wr(OFF_CTRL_TWO, 16'(i << CTRL2_REF));
			step(3);
			chk(16'({ref_positive_ext_o, ref_negative_ext_o}),
				16'((i < 4) ? {i[0], i[1]} : 2'b00), "ref");
		end
		// every format, one sequence per interrupt
		wr(OFF_CTRL_TWO, 16'h0000);
		wr(OFF_CTRL_THREE, 16'h0000);
		for (i = 0; i < 4; i++) begin
			level = (i[0]) ? 10'h0A5 : 10'h35A;
			conv(16'h8000 | 16'(i << CTRL1_FORMAT));
			wr(OFF_BUF_INDEX, 16'h0000);
			rchk(OFF_BUF_DATA, 16'hFFFF, fmt(i, level), "result");
		end
		// four sequences per interrupt, pointer rewinds
		wr(OFF_CTRL_TWO, 16'h000C);
		b = irqs;
		for (i = 0; i < 5; i++) begin
			level = 10'(i * 100 + 7);
			conv(16'h8000);
			step(4);
			chk(16'(irqs - b), 16'((i > 2) ? 1 : 0), "irqs");
		end
		for (i = 0; i < 4; i++) begin
			wr(OFF_BUF_INDEX, 16'(i));
			rchk(OFF_BUF_DATA, 16'hFFFF, 16'((i == 0) ? 407 : i * 100 + 7),
				"word");
		end
		wr(OFF_CTRL_ONE, 16'h0000);
		wr(OFF_CTRL_ONE, 16'h8000);
		wr(OFF_BUF_INDEX, 16'h0001);
		rchk(OFF_BUF_DATA, 16'hFFFF, 16'h0000, "cleared");
		// alternate mux, then scan of channels 2 and 5
		wr(OFF_CHAN_SEL, 16'h0985);
		wr(OFF_CTRL_TWO, 16'h0009);
		for (i = 0; i < 3; i++) begin
			conv(16'h8000);
			chk(16'(mx), 16'(i[0] ? 6'h09 : 6'h25), "mux");
		end
		wr(OFF_SCAN_LOW, 16'h0024);
		wr(OFF_CTRL_TWO, 16'h0408);
		for (i = 0; i < 3; i++) begin
			conv(16'h8000);
			chk(16'(mx[4:0]), 16'(i[0] ? 5 : 2), "scan");
		end
		// edge triggers fire, reserved codes never do
		wr(OFF_CTRL_TWO, 16'h0000);
		for (i = 0; i < 6; i++) begin
			g = (i < 4) ? (1 << i) : 0;
			w = (i == 4) ? 5 : (i == 5) ? 3 : (i == 3) ? 6 : (i == 2) ? 4 : i + 1;
			wr(OFF_CTRL_ONE, 16'h8002 | 16'(w << CTRL1_TRIGGER));
			b = irqs;
			step(3);
			trig <= (i < 4) ? 4'(g) : 4'hF;
			step(6);
			trig <= 4'h0;
			step(40);
			chk(16'(irqs - b), 16'((i < 4) ? 1 : 0), "trigger");
			wr(OFF_CTRL_ONE, 16'h0000);
		end
		// automatic sampling: T=4 periods, divider setting 2 (three clocks per period)
		wr(OFF_CTRL_THREE, 16'h0402);
		wr(OFF_CTRL_ONE, 16'h80E6);
		until_smp(1'b1, w);
		until_smp(1'b0, w);
		until_smp(1'b1, g);
		until_smp(1'b0, w);
		chk(16'(w >= 12 && w <= 17), 16'h0001, "sample time");
		chk(16'(g >= 30 && g <= 38), 16'h0001, "restart");
		// stop in idle only when asked to
		for (i = 0; i < 2; i++) begin
			wr(OFF_CTRL_ONE, 16'h80E6 | 16'(i << CTRL1_IDLE_STOP));
			idle_mode_i <= 1'b1;
			step(80);
			b = irqs;
			step(300);
			chk(16'(irqs == b), 16'(i), "idle");
			idle_mode_i <= 1'b0;
		end
		// split buffer: half status follows interrupts
		wr(OFF_CTRL_ONE, 16'h0000);
		wr(OFF_CTRL_TWO, 16'h0002);
		wr(OFF_CTRL_ONE, 16'h80E6);
		for (i = 0; i < 2; i++) begin
			b = irqs;
			for (g = 0; g < 200 && irqs == b; g++) step(1);
			rd(OFF_CTRL_TWO, h);
			chk(h & 16'h0080, 16'(i[0] ? 0 : 16'h0080), "half");
		end
		// internal rc clock: progress only on its edges
		wr(OFF_CTRL_THREE, 16'h8100);
		step(10);
		b = irqs;
		step(200);
		chk(16'(irqs - b), 16'h0000, "rc still");
		for (g = 0; g < 400; g++) @(posedge clock_i) rc_tick_i <= g[1];
		step(1);
		chk(16'(irqs != b), 16'h0001, "rc run");
		results();
	end
endmodule
